/* hw/quad_serial_master.sv */
// Top: mode register of the quad serial master, AXI4-Lite slave, serial clock and shifter.
// Assumes one clock, synchronous low reset, and a master keeping AXI4-Lite handshakes.
// Function
// RQ1: Receive sample edge picked from idle level and sample phase bit.
// RQ2: Transmit launch edge picked from idle level and launch phase bit.
// RQ3: Idle level bit sets serial clock level outside transfers.
// RQ4: Soft reset bit resets block, write-only, clears itself.
// RQ5: Run enable low gates clocks and drives outputs inactive.
// RQ6: Software programs both phase bits alike for modes 0 and 3.
// RQ7: At 48 MHz quad, software uses idle 0, sample 1, launch 0.
// RQ8: Below 48 MHz, software uses idle 0 with both phases 0.
// RQ9: Serial clock is system clock divided by field, zero divides 256; code divides by twice the field (512 for zero).
// RQ10: After reset idle level, phases and run enable read zero.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module quad_serial_master
(
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial pins
  output logic             sck,
  output logic             mosi,
  output logic             cs_n,
  input  wire logic        miso
);

  // Mode register fields
  logic       run_q;
  logic       idle_q;
  logic       launch_q;
  logic       sample_q;
  logic [7:0] div_q;
  logic       srst_q;

  // Write channel capture
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        start_q;
  logic [7:0]  txd_q;

  logic        do_write;
  logic        hit_mode_w;
  logic        hit_xfer_w;
  logic        hit_stat_w;
  logic        wr_ok;
  logic        lane0;
  logic        lane1;
  logic        lane2;
  logic        do_read;
  logic        hit_mode_r;
  logic        hit_stat_r;
  logic        rd_ok;
  logic [31:0] mode_word;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  // Engine side
  logic       core_rst_n;
  logic       core_ce;
  logic       tick;
  logic       eng_sck;
  logic       eng_mosi;
  logic       eng_cs_n;
  logic       busy;
  logic [7:0] rx_byte;

  // Write decode: response issued once address and data are both held
  assign do_write   = aw_held_q && w_held_q && !s_axi_bvalid;
  assign hit_mode_w = (awaddr_q[7:2] == qsm_pkg::MODE_OFFS[7:2]);
  assign hit_xfer_w = (awaddr_q[7:2] == qsm_pkg::XFER_OFFS[7:2]);
  assign hit_stat_w = (awaddr_q[7:2] == qsm_pkg::STAT_OFFS[7:2]);
  assign wr_ok      = hit_mode_w || hit_xfer_w || hit_stat_w;
  assign lane0      = wstrb_q[0];
  assign lane1      = wstrb_q[1];
  assign lane2      = wstrb_q[2];

  // Read decode
  assign do_read    = s_axi_arvalid && s_axi_arready;
  assign hit_mode_r = (s_axi_araddr[7:2] == qsm_pkg::MODE_OFFS[7:2]);
  assign hit_stat_r = (s_axi_araddr[7:2] == qsm_pkg::STAT_OFFS[7:2]);
  assign rd_ok      = hit_mode_r || hit_stat_r
                      || (s_axi_araddr[7:2] == qsm_pkg::XFER_OFFS[7:2]);

  // RQ4 soft reset reads as zero
  always_comb
  begin
    mode_word = 32'h0000_0000;
    mode_word[qsm_pkg::RUN_BIT] = run_q;
    mode_word[qsm_pkg::IDLE_BIT] = idle_q;
    mode_word[qsm_pkg::LAUNCH_BIT] = launch_q;
    mode_word[qsm_pkg::SAMPLE_BIT] = sample_q;
    mode_word[qsm_pkg::DIV_MSB:qsm_pkg::DIV_LSB] = div_q;
  end

  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[qsm_pkg::RXD_MSB:qsm_pkg::RXD_LSB] = rx_byte;
    stat_word[qsm_pkg::BUSY_BIT] = busy;
  end

  assign rd_word = hit_mode_r ? mode_word : (hit_stat_r ? stat_word : 32'h0000_0000);

  // AXI write channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= qsm_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? qsm_pkg::RESP_OKAY : qsm_pkg::RESP_SLVERR;
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI read channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= qsm_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? qsm_pkg::RESP_OKAY : qsm_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Mode register; soft reset also clears it, along with the divider and shifter (bus channels keep their state)
  always_ff @(posedge aclk)
  begin
    // RQ10 reset values zero
    if (!aresetn || srst_q)
    begin
      run_q    <= 1'b0;
      idle_q   <= 1'b0;
      launch_q <= 1'b0;
      sample_q <= 1'b0;
      div_q    <= qsm_pkg::DIV_RESET;
    end
    else if (ce && do_write && hit_mode_w && !(lane0 && wdata_q[qsm_pkg::SRST_BIT]))
    begin
      if (lane0)
        run_q <= wdata_q[qsm_pkg::RUN_BIT];
      if (lane1)
      begin
        idle_q   <= wdata_q[qsm_pkg::IDLE_BIT];
        launch_q <= wdata_q[qsm_pkg::LAUNCH_BIT];
        sample_q <= wdata_q[qsm_pkg::SAMPLE_BIT];
      end
      if (lane2)
        div_q <= wdata_q[qsm_pkg::DIV_MSB:qsm_pkg::DIV_LSB];
    end
  end

  // RQ4 self-clearing soft reset pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      srst_q <= 1'b0;
    else if (ce)
      srst_q <= do_write && hit_mode_w && lane0 && wdata_q[qsm_pkg::SRST_BIT];
  end

  // Transfer start: accepted only while running and idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_q <= 1'b0;
      txd_q   <= 8'h00;
    end
    else if (ce)
    begin
      start_q <= do_write && hit_xfer_w && lane0 && run_q && !busy && !start_q;
      if (do_write && hit_xfer_w && lane0)
        txd_q <= wdata_q[qsm_pkg::TXD_MSB:qsm_pkg::TXD_LSB];
    end
  end

  // RQ5 gate engine when disabled
  assign core_ce    = ce && run_q;
  assign core_rst_n = aresetn && !srst_q && run_q;

  sck_divider u_div
  (
    .aclk    (aclk),
    .aresetn (core_rst_n),
    .ce      (core_ce),
    .run     (busy),
    .div     (div_q),
    .tick    (tick)
  );

  shift_engine u_eng
  (
    .aclk         (aclk),
    .rst_n        (core_rst_n),
    .ce           (core_ce),
    .tick         (tick),
    .idle_level   (idle_q),
    .sample_phase (sample_q),
    .launch_phase (launch_q),
    .start        (start_q),
    .tx_byte      (txd_q),
    .miso         (miso),
    .sck          (eng_sck),
    .mosi         (eng_mosi),
    .cs_n         (eng_cs_n),
    .busy         (busy),
    .rx_byte      (rx_byte)
  );

  // RQ5 inactive pin levels, RQ3 idle clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck  <= 1'b0;
      mosi <= 1'b0;
      cs_n <= 1'b1;
    end
    else if (ce)
    begin
      sck  <= run_q ? eng_sck : idle_q;
      mosi <= run_q ? eng_mosi : 1'b0;
      cs_n <= run_q ? eng_cs_n : 1'b1;
    end
  end

endmodule
`default_nettype wire

/* hw/qsm_pkg.sv */
// Package: register map, field positions and reset values of the serial mode block.
// Assumes a 32-bit AXI4-Lite register bus and a single 25 MHz clock domain.
package qsm_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] MODE_OFFS = 8'h00;
  localparam logic [7:0] XFER_OFFS = 8'h04;
  localparam logic [7:0] STAT_OFFS = 8'h08;

  // Mode register field positions
  localparam int unsigned RUN_BIT    = 0;
  localparam int unsigned SRST_BIT   = 1;
  localparam int unsigned IDLE_BIT   = 8;
  localparam int unsigned LAUNCH_BIT = 9;
  localparam int unsigned SAMPLE_BIT = 10;
  localparam int unsigned DIV_LSB    = 16;
  localparam int unsigned DIV_MSB    = 23;

  // Transfer register: write starts a shift of the low byte
  localparam int unsigned TXD_LSB = 0;
  localparam int unsigned TXD_MSB = 7;

  // Status register
  localparam int unsigned RXD_LSB  = 0;
  localparam int unsigned RXD_MSB  = 7;
  localparam int unsigned BUSY_BIT = 8;

  localparam logic [7:0] DIV_RESET  = 8'h00;
  localparam logic [8:0] DIV_ZERO_N = 9'h100;
  localparam logic [3:0] BITS_BYTE  = 4'h8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_TRAIL = 2'b10
  } shift_state_type;

endpackage

/* hw/sck_divider.sv */
// Serial clock tick generator: one pulse every N system clocks.
// Assumes the divider value is stable while a transfer runs.
`timescale 1ns/100ps
`default_nettype none
module sck_divider
(
  // Clock and control
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       run,
  // Divider setting, zero means 256
  input  wire logic [7:0] div,
  // Half-period tick
  output logic            tick
);

  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic [8:0] limit;
  logic       at_end;

  // RQ9 divide by field, zero as 256
  assign limit  = (div == 8'h00) ? qsm_pkg::DIV_ZERO_N : {1'b0, div};
  assign at_end = (cnt_q + 9'h001 >= limit);
  assign cnt_d  = (!run || at_end) ? 9'h000 : cnt_q + 9'h001;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 9'h000;
      tick  <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      tick  <= run && at_end;
    end
  end

endmodule
`default_nettype wire

/* hw/shift_engine.sv */
// Byte shifter: one edge per divider tick, edge choice from polarity and phase bits.
// Assumes start arrives only while busy is low.
`timescale 1ns/100ps
`default_nettype none
module shift_engine
(
  // Clock and control
  input  wire logic       aclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       tick,
  // Mode bits
  input  wire logic       idle_level,
  input  wire logic       sample_phase,
  input  wire logic       launch_phase,
  // Transfer request
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  // Serial pins
  input  wire logic       miso,
  output logic            sck,
  output logic            mosi,
  output logic            cs_n,
  // Result
  output logic            busy,
  output logic [7:0]      rx_byte
);

  qsm_pkg::shift_state_type st_q;
  logic [7:0] sh_q;
  logic [3:0] nbit_q;
  logic       sck_next;
  logic       rising;
  logic       sample_now;
  logic       launch_now;
  logic [7:0] sh_next;
  logic [3:0] last_pair;
  logic       first_edge;
  logic       last_edge;

  assign sck_next = ~sck;
  assign rising   = (sck_next == 1'b1);
  // RQ1 sample edge select
  assign sample_now = (idle_level ^ sample_phase) ? !rising : rising;
  // RQ2 launch edge select
  assign launch_now = (idle_level ^ launch_phase) ? rising : !rising;
  assign sh_next    = {sh_q[6:0], miso};
  assign last_pair  = qsm_pkg::BITS_BYTE - 4'h1;
  // First edge never launches: the first bit is already out when cs_n falls
  assign first_edge = (st_q == qsm_pkg::ST_LEAD) && (nbit_q == 4'h0);
  assign last_edge  = (st_q == qsm_pkg::ST_TRAIL) && (nbit_q == last_pair);

  always_ff @(posedge aclk)
  begin
    if (!rst_n)
    begin
      st_q    <= qsm_pkg::ST_IDLE;
      sh_q    <= 8'h00;
      nbit_q  <= 4'h0;
      sck     <= 1'b0;
      mosi    <= 1'b0;
      cs_n    <= 1'b1;
      busy    <= 1'b0;
      rx_byte <= 8'h00;
    end
    else if (ce)
    begin
      case (st_q)
        qsm_pkg::ST_IDLE:
        begin
          // RQ3 idle clock level
          sck <= idle_level;
          if (start)
          begin
            st_q   <= qsm_pkg::ST_LEAD;
            sh_q   <= tx_byte;
            mosi   <= tx_byte[7];
            nbit_q <= 4'h0;
            cs_n   <= 1'b0;
            busy   <= 1'b1;
          end
        end
        qsm_pkg::ST_LEAD, qsm_pkg::ST_TRAIL:
        begin
          if (tick)
          begin
            sck  <= sck_next;
            st_q <= (st_q == qsm_pkg::ST_LEAD) ? qsm_pkg::ST_TRAIL : qsm_pkg::ST_LEAD;
            // Count clock periods, so every mode ends after sixteen edges
            if (st_q == qsm_pkg::ST_TRAIL)
              nbit_q <= nbit_q + 4'h1;
            if (sample_now)
              sh_q <= sh_next;
            // Same-edge modes launch the bit behind the one shifted out now
            if (launch_now && !first_edge)
              mosi <= sample_now ? sh_q[6] : sh_q[7];
            if (last_edge)
            begin
              st_q    <= qsm_pkg::ST_IDLE;
              sck     <= idle_level;
              cs_n    <= 1'b1;
              busy    <= 1'b0;
              rx_byte <= sample_now ? sh_next : sh_q;
            end
          end
        end
        default:
          st_q <= qsm_pkg::ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

/* verification/qsm_assertions.sv */
// Checker: bus handshake and serial frame properties of the quad serial master.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module qsm_assertions
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Serial pins
  input wire logic        sck,
  input wire logic        cs_n
);
  logic [7:0] ra_q;
  logic [4:0] edges_q;
  logic       sck0_q;
  logic       cs_q;
  logic       sck_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk)
  begin
    cs_q <= cs_n;
    sck_q <= sck;
    if (s_axi_arvalid && s_axi_arready)
      ra_q <= s_axi_araddr;
    if (cs_q && !cs_n)
      edges_q <= 5'h00;
    else if (!cs_q && sck != sck_q)
      edges_q <= edges_q + 5'h01;
    if (cs_n)
      sck0_q <= sck;
  end
  property p_frame_idle;
    $rose(cs_n) |-> sck == sck0_q;
  endproperty
  a_frame_idle: assert property (p_frame_idle) else $error("sck not at idle level after frame");
  property p_frame_edges;
    $rose(cs_n) |=> edges_q == 5'h10;
  endproperty
  a_frame_edges: assert property (p_frame_edges) else $error("frame without 16 sck edges");
  property p_rst_pins;
    $rose(aresetn) |-> cs_n && !sck;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins not idle after reset");
  property p_mode_rsvd;
    s_axi_rvalid && ra_q == 8'h00 |-> s_axi_rdata[7:1] == 7'h00 && s_axi_rdata[15:11] == 5'h00
      && s_axi_rdata[31:24] == 8'h00;
  endproperty
  a_mode_rsvd: assert property (p_mode_rsvd) else $error("soft reset or reserved bit reads set");
  property p_unmapped;
    s_axi_rvalid && ra_q > 8'h08 |-> s_axi_rresp == qsm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after) else $error("read data late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped before taken");
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> (!s_axi_bvalid && !s_axi_awready) ##1 !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write response repeated");
endmodule
bind quad_serial_master qsm_assertions i_qsm_assertions (.*);
`default_nettype wire

/* verification/spi_slave_model.sv */
// Serial flash stand-in: answers one byte per frame and records the byte shifted in.
// Assumes pins change on aclk edges and a half period of four clocks or more.
`timescale 1ns/100ps
`default_nettype none
module spi_slave_model
(
  // Clock and serial pins
  input  wire logic       aclk,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output var  logic       miso,
  // Mode in use, reply and results
  input  wire logic       idle,
  input  wire logic       s_ph,
  input  wire logic       l_ph,
  input  wire logic [7:0] reply,
  output var  logic [7:0] got,
  output var  logic [8:0] gap
);
  logic       sck_q = 1'b0;
  logic       cs_q = 1'b1;
  logic [3:0] cnt = 4'h0;
  logic [8:0] run = 9'h000;
  wire        edge_seen = sck ^ sck_q;
  // master samples on rising when idle equals phase
  wire        m_smp = edge_seen && (sck == (idle == s_ph));
  // master launches on falling when idle equals phase
  wire        m_lch = edge_seen && (sck == (idle != l_ph));
  initial
  begin
    miso = 1'b0;
    got = 8'h00;
    gap = 9'h000;
  end
  always @(posedge aclk)
  begin
    sck_q <= sck;
    cs_q <= cs_n;
    run <= edge_seen ? 9'h001 : run + 9'h001;
    if (edge_seen)
      gap <= run;
    // Released line wanders so a stale bit never passes
    if (cs_n)
      miso <= !miso;
    else if (cs_q)
    begin
      miso <= reply[7];
      cnt <= 4'h0;
    end
    else
    begin
      if (m_smp)
        cnt <= cnt + 4'h1;
      else if (edge_seen)
        miso <= reply[3'h7 - cnt[2:0]];
    end
    // Last edge may come with cs_n rising, so go by the level before it
    if (!cs_q && edge_seen && !m_lch)
      got <= {got[6:0], mosi};
  end
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Bench: register access over AXI4-Lite and one serial frame per mode setting.
// Assumes the partner model and the checker bind are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        aclk;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        sck, mosi, cs_n, miso;
  logic        idle = 1'b0;
  logic        s_ph = 1'b0;
  logic        l_ph = 1'b0;
  logic [7:0]  reply = 8'h00;
  logic [7:0]  got;
  logic [8:0]  gap;
  int          err_count = 0;
  int          n_compared = 0;
  // settings: divider, idle level, launch phase, sample phase
  logic [10:0] tbl [5] = '{11'h020, 11'h027, 11'h021, 11'h02c, 11'h000};
  quad_serial_master i_quad_serial_master
  (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sck, .mosi, .cs_n, .miso
  );
  spi_slave_model i_spi_slave_model (.aclk, .sck, .cs_n, .mosi, .miso, .idle, .s_ph, .l_ph, .reply, .got, .gap);
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic tally_and_finish(input int extra);
    err_count += extra;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", s, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 99);
    s_axi_bready <= 1'b0;
    if (n >= 99)
      tally_and_finish(1);
    chk("write response", 32'(s_axi_bresp), 32'(qsm_pkg::RESP_OKAY));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 99);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 99)
      tally_and_finish(1);
  endtask
  initial
  begin
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0]  r;
    logic [10:0] e;
    logic [7:0]  tx;
    int          n;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, d, r);
    chk("mode after reset", d, 32'h0);
    chk("sck after reset", 32'(sck), 32'h0);
    rd(8'h40, d, r);
    chk("unmapped response", 32'(r), 32'(qsm_pkg::RESP_SLVERR));
    $display("test reset done");
    // Run enable low, so this transfer must be dropped
    wr(8'h04, 32'h0000_005a);
    rd(8'h08, d, r);
    chk("busy while disabled", 32'(d[8]), 32'h0);
    chk("cs_n while disabled", 32'(cs_n), 32'h1);
    $display("test disabled done");
    for (int i = 0; i < 5; i++)
    begin
      e = tbl[i];
      m = {8'h00, e[10:3], 5'h00, e[0], e[1], e[2], 8'h01};
      {idle, l_ph, s_ph} <= e[2:0];
      reply <= 8'hc5 ^ 8'(i);
      tx = 8'h3a + 8'(i);
      wr(8'h00, m);
      rd(8'h00, d, r);
      chk("mode readback", d, m);
      chk("idle level", 32'(sck), 32'(e[2]));
      wr(8'h04, 32'(tx));
      n = 0;
      do
      begin
        rd(8'h08, d, r);
        n++;
      end
      while (d[8] !== 1'b0 && n < 3000);
      if (n >= 3000)
        tally_and_finish(1);
      // Pins and the partner lag the engine by two clocks
      repeat (2) @(posedge aclk);
      chk("received byte", 32'(d[7:0]), 32'(8'hc5 ^ 8'(i)));
      chk("sent byte", 32'(got), 32'(tx));
      chk("half period", 32'(gap), (e[10:3] == 8'h00) ? 32'h100 : 32'(e[10:3]));
      chk("sck after frame", 32'(sck), 32'(e[2]));
      $display("test mode %0d done", i);
    end
    wr(8'h00, 32'h0000_0302);
    rd(8'h00, d, r);
    chk("mode after soft reset", d, 32'h0);
    wr(8'h00, 32'h0000_0100);
    @(posedge aclk);
    chk("idle high while disabled", 32'(sck), 32'h1);
    $display("test soft reset done");
    tally_and_finish(0);
  end
endmodule
`default_nettype wire
